// *** core/fdm_fault_manager.sv ***
// Fault detection manager: latches fault flags, drives interrupt and recovery.
// Assumes fault conditions arrive as synchronous levels from analog monitors,
// and that the serial port decodes host reads, writes and mode commands.
//
// Contract
// R1 - Supply over, under and regulator-hot set flags 3,2,1; interrupt code 0101.
// R2 - Regulator overtemperature: regulator off, reset, then sleep, no flag.
// R3 - Receive short in normal modes disables transmitter, flag bit 3, re-enable when clear.
// R4 - Transmit low over 1 s disables transmitter, flag bit 2; driver hot bit 1; code 0100.
// R5 - High side hot: drivers off, all flags set, code 0010, re-enable on write.
// R6 - Floating watchdog pin selects 150 ms internal timebase, error flag bit 2.
// R7 - In reset, regulator under with supply-under flag clear goes to sleep.
// R8 - Fault flags stay readable after return to normal modes.
// R9 - Interrupts only in normal, normal-request or stop mode.
// R10 - Masked source keeps interrupt high and sets no source flag.
// R11 - Supply over in normal with shutdown enable disables drivers until write.
// R12 - Open-load and current-limit flags per driver, no interrupt.
// R13 - Watchdog clear outside window or overflow resets host, timeout flag bit 3.
// R14 - No normal command within request timeout re-enters reset mode.
// R15 - Reset held to host while regulator under, except in sleep.
// R16 - Battery-fail flag bit 0 after collapse then power-up, cleared when gone.
`include "fdm_cfg.svh"

module fdm_fault_manager
   import fdm_pkg::*;
#(
   parameter int unsigned DOM_CYC    = `FDM_DOM_CYC,
   parameter int unsigned NRQ_CYC    = `FDM_NRQ_CYC,
   parameter int unsigned WD_INT_CYC = `FDM_WD_INT_CYC
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   // Fault condition levels
   input  wire logic       supply_collapse,
   input  wire logic       supply_over,
   input  wire logic       supply_under,
   input  wire logic       regulator_under,
   input  wire logic       regulator_warn,
   input  wire logic       regulator_hot,
   input  wire logic       receive_short,
   input  wire logic       transmit_in,
   input  wire logic       bus_driver_hot,
   input  wire logic       high_side_hot,
   input  wire logic [1:0] open_load,
   input  wire logic [1:0] current_limit,
   input  wire logic       watchdog_config_floating,
   input  wire logic       watchdog_config_grounded,
   // Host requests decoded from the serial port, plus the wake-up event
   input  wire logic       cmd_normal,
   input  wire logic       cmd_stop,
   input  wire logic       cmd_sleep,
   input  wire logic       watchdog_clear,
   input  wire logic       wake_up,
   input  wire logic       high_side_control_wr,
   input  wire logic [1:0] high_side_control_on,
   input  wire logic       high_voltage_shutdown_enable,
   input  wire logic [2:0] interrupt_mask,
   input  wire logic       rd_supply_status,
   input  wire logic       rd_bus_transceiver_status,
   input  wire logic       rd_high_side_status,
   input  wire logic       rd_watchdog_status,
   input  wire logic       rd_interrupt_source,
   // Outputs
   output logic [3:0]      supply_status,
   output logic [3:0]      bus_transceiver_status,
   output logic [3:0]      high_side_status,
   output logic [3:0]      watchdog_status,
   output logic [3:0]      interrupt_source,
   output logic            irq_n,
   output logic            host_reset_n,
   output logic            regulator_enable,
   output logic            transmitter_enable,
   output logic [1:0]      high_side_enable,
   output logic            watchdog_internal_base,
   output fdm_mode_t       mode
);

   // ************************************************************
   // Mode sequencing and watchdog
   // ************************************************************
   fdm_mode_t   mode_q, mode_d;
   logic [31:0] tmr_q, tmr_d;
   logic        wd_to_q, wd_to_d;
   logic        wd_err_q, wd_err_d;
   logic        wd_base_q, wd_base_d;
   logic        reg_off_q, reg_off_d;
   logic        wd_fault;
   logic [3:0]  supply_status_q, supply_status_d;

   // Window: first half closed, second half open, full period overflows
   assign wd_fault = (mode_q == FDM_NORMAL) && !watchdog_config_grounded &&
                     ((watchdog_clear && (tmr_q < WD_INT_CYC / 2)) ||
                      (tmr_q >= WD_INT_CYC - 1));

   always_comb begin
      mode_d    = mode_q;
      tmr_d     = tmr_q + 32'h1;
      wd_to_d   = wd_to_q;
      wd_err_d  = wd_err_q;
      wd_base_d = wd_base_q;
      reg_off_d = reg_off_q;
      case (mode_q)
         FDM_RESET: begin
            tmr_d = 32'h0;
            wd_err_d  = watchdog_config_floating; // R6
            wd_base_d = watchdog_config_floating; // R6
            if (regulator_under && !supply_status_q[`FDM_SUP_UNDER_BIT]) begin
               mode_d = FDM_SLEEP; // R7
            end else if (reg_off_q) begin
               mode_d = FDM_SLEEP; // R2
            end else if (!regulator_under) begin
               mode_d = watchdog_config_grounded ? FDM_NORMAL : FDM_NORMAL_REQ;
            end
         end
         FDM_NORMAL_REQ: begin
            if (cmd_normal) begin
               mode_d  = FDM_NORMAL;
               tmr_d   = 32'h0;
               wd_to_d = 1'b0;
            end else if (tmr_q >= NRQ_CYC - 1) begin
               mode_d = FDM_RESET; // R14
            end
         end
         FDM_NORMAL: begin
            if (wd_fault) begin
               mode_d  = FDM_RESET; // R13
               wd_to_d = 1'b1; // R13
            end else if (cmd_sleep) begin
               mode_d = FDM_SLEEP;
            end else if (cmd_stop) begin
               mode_d = FDM_STOP;
            end else if (watchdog_clear) begin
               tmr_d = 32'h0;
            end
         end
         FDM_STOP: begin
            tmr_d = 32'h0;
            if (wake_up) begin
               mode_d = FDM_NORMAL_REQ;
            end
         end
         FDM_SLEEP: begin
            tmr_d = 32'h0;
            if (wake_up) begin
               mode_d    = FDM_RESET;
               reg_off_d = 1'b0;
            end
         end
         default: mode_d = FDM_RESET;
      endcase
      if (regulator_hot && mode_q != FDM_SLEEP) begin
         mode_d    = FDM_RESET; // R2
         reg_off_d = 1'b1; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_q    <= FDM_RESET;
         tmr_q     <= 32'h0;
         wd_to_q   <= 1'b0;
         wd_err_q  <= 1'b0;
         wd_base_q <= 1'b0;
         reg_off_q <= 1'b0;
      end else begin
         mode_q    <= mode_d;
         tmr_q     <= tmr_d;
         wd_to_q   <= wd_to_d;
         wd_err_q  <= wd_err_d;
         wd_base_q <= wd_base_d;
         reg_off_q <= reg_off_d;
      end
   end

   // ************************************************************
   // Fault flags and driver shutdown
   // ************************************************************
   logic [3:0]  bus_status_q, bus_status_d;
   logic [3:0]  hs_status_q, hs_status_d;
   logic [3:0]  src_q, src_d;
   logic [31:0] dom_cnt_q, dom_cnt_d;
   logic        tx_off_q, tx_off_d;
   logic [1:0]  hs_off_q, hs_off_d;
   logic        normal_any, irq_mode, dom_hit;
   logic        sup_ev, bus_ev, hs_ev;
   logic [3:0]  hs_live;

   assign normal_any = (mode_q == FDM_NORMAL) || (mode_q == FDM_NORMAL_REQ);
   assign irq_mode   = normal_any || (mode_q == FDM_STOP); // R9
   assign dom_hit    = (dom_cnt_q >= DOM_CYC);
   assign sup_ev     = (supply_over || supply_under) && normal_any ||
                       regulator_warn && (mode_q != FDM_STOP) && (mode_q != FDM_SLEEP);
   assign bus_ev     = normal_any && (receive_short || dom_hit || bus_driver_hot);
   assign hs_ev      = normal_any && high_side_hot;

   // Per-driver open-load and current-limit live bits
   generate
      for (genvar i = 0; i < 2; i++) begin : g_hs
         assign hs_live[2*i]   = current_limit[i]; // R12
         assign hs_live[2*i+1] = open_load[i]; // R12
      end
   endgenerate

   always_comb begin
      supply_status_d = supply_status_q;
      bus_status_d    = bus_status_q;
      src_d           = src_q;
      dom_cnt_d       = transmit_in ? 32'h0 : (dom_hit ? dom_cnt_q : dom_cnt_q + 32'h1);
      tx_off_d        = tx_off_q;
      hs_off_d        = hs_off_q;
      // Battery fail follows the collapse condition
      supply_status_d[`FDM_SUP_BATTERY_FAIL_FLAG_BIT] = supply_collapse; // R16
      // Reads clear sticky flags; new events below win over the clear
      if (rd_supply_status) begin
         supply_status_d[3:1] = 3'h0; // R8
      end
      if (rd_bus_transceiver_status) begin
         bus_status_d = `FDM_STAT_RST;
      end
      if (rd_interrupt_source) begin
         src_d = `FDM_SRC_NONE;
      end
      if (normal_any && supply_over) begin
         supply_status_d[`FDM_SUP_OVER_BIT] = 1'b1; // R1
      end
      if (normal_any && supply_under) begin
         supply_status_d[`FDM_SUP_UNDER_BIT] = 1'b1; // R1
      end
      if (regulator_warn && mode_q != FDM_STOP && mode_q != FDM_SLEEP) begin
         supply_status_d[`FDM_SUP_HOT_BIT] = 1'b1; // R1
      end
      if (normal_any && receive_short) begin
         bus_status_d[`FDM_BUS_SHORT_BIT] = 1'b1; // R3
         tx_off_d = 1'b1; // R3
      end
      if (normal_any && dom_hit) begin
         bus_status_d[`FDM_BUS_DOM_BIT] = 1'b1; // R4
         tx_off_d = 1'b1; // R4
      end
      if (normal_any && bus_driver_hot) begin
         bus_status_d[`FDM_BUS_HOT_BIT] = 1'b1; // R4
         tx_off_d = 1'b1;
      end
      if (tx_off_q && !receive_short && !bus_driver_hot && transmit_in) begin
         tx_off_d = 1'b0; // R3
      end
      // High side re-enable by control write once conditions are gone
      if (high_side_control_wr && !high_side_hot && !supply_over) begin
         hs_off_d = 2'b00; // R5 R11
      end
      if (hs_ev) begin
         hs_off_d = 2'b11; // R5
      end
      if (mode_q == FDM_NORMAL && supply_over && high_voltage_shutdown_enable) begin
         hs_off_d = 2'b11; // R11
      end
      // Source code, priority high side, bus, supply; masked sources set nothing
      if (irq_mode) begin // R9
         if (hs_ev && interrupt_mask[2]) begin // R10
            src_d = `FDM_SRC_HS; // R5
         end else if (bus_ev && interrupt_mask[1]) begin // R10
            src_d = `FDM_SRC_BUS; // R4
         end else if (sup_ev && interrupt_mask[0]) begin // R10
            src_d = `FDM_SRC_SUPPLY; // R1
         end
      end
   end

   always_comb begin
      hs_status_d = hs_live;
      if (hs_ev) begin
         hs_status_d = 4'hf; // R5
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         supply_status_q <= `FDM_STAT_RST;
         bus_status_q    <= `FDM_STAT_RST;
         hs_status_q     <= `FDM_STAT_RST;
         src_q           <= `FDM_SRC_NONE;
         dom_cnt_q       <= 32'h0;
         tx_off_q        <= 1'b0;
         hs_off_q        <= 2'b00;
      end else begin
         supply_status_q <= supply_status_d;
         bus_status_q    <= bus_status_d;
         hs_status_q     <= hs_status_d;
         src_q           <= src_d;
         dom_cnt_q       <= dom_cnt_d;
         tx_off_q        <= tx_off_d;
         hs_off_q        <= hs_off_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign supply_status          = supply_status_q;
   assign bus_transceiver_status = bus_status_q;
   assign high_side_status       = hs_status_q;
   assign watchdog_status        = {wd_to_q, wd_err_q, 2'b00};
   assign interrupt_source       = src_q;
   assign irq_n                  = (src_q == `FDM_SRC_NONE); // R10
   assign host_reset_n           = (mode_q != FDM_RESET) &&
                                   !(regulator_under && mode_q != FDM_SLEEP); // R15
   assign regulator_enable       = !reg_off_q && (mode_q != FDM_SLEEP); // R2
   assign transmitter_enable     = normal_any && !tx_off_q; // R3 R4
   assign high_side_enable       = high_side_control_on & ~hs_off_q;
   assign watchdog_internal_base = wd_base_q; // R6
   assign mode                   = mode_q;

endmodule

// *** core/fdm_cfg.svh ***
// Constants for the fault detection manager: bit positions, source codes, timing.
// Assumes a 125 MHz system clock; included by the fault manager design only.
`ifndef FDM_CFG_SVH
`define FDM_CFG_SVH

// Supply status bits
`define FDM_SUP_BATTERY_FAIL_FLAG_BIT   0
`define FDM_SUP_HOT_BIT       1
`define FDM_SUP_UNDER_BIT     2
`define FDM_SUP_OVER_BIT      3
// Bus transceiver status bits
`define FDM_BUS_HOT_BIT       1
`define FDM_BUS_DOM_BIT       2
`define FDM_BUS_SHORT_BIT     3
// High side status bits
`define FDM_HS1_CL_BIT        0
`define FDM_HS1_OP_BIT        1
`define FDM_HS2_CL_BIT        2
`define FDM_HS2_OP_BIT        3
// Watchdog status bits
`define FDM_WD_ERR_BIT        2
`define FDM_WD_TO_BIT         3
// Interrupt source codes
`define FDM_SRC_NONE          4'h0
`define FDM_SRC_SUPPLY        4'h5
`define FDM_SRC_BUS           4'h4
`define FDM_SRC_HS            4'h2
// Status reset value
`define FDM_STAT_RST          4'h0
// Timing
`define FDM_CLK_HZ            125000000
`define FDM_DOM_TIME_MS       1000
`define FDM_NRQ_TIME_MS       150
`define FDM_WD_INT_TIME_MS    150
`define FDM_DOM_CYC           ((`FDM_CLK_HZ / 1000) * `FDM_DOM_TIME_MS)
`define FDM_NRQ_CYC           ((`FDM_CLK_HZ / 1000) * `FDM_NRQ_TIME_MS)
`define FDM_WD_INT_CYC        ((`FDM_CLK_HZ / 1000) * `FDM_WD_INT_TIME_MS)

`endif

// *** core/fdm_pkg.sv ***
// Types shared by the fault detection manager.
// Assumes nothing beyond the constants header.
package fdm_pkg;

   typedef enum logic [2:0] {
      FDM_RESET,
      FDM_NORMAL_REQ,
      FDM_NORMAL,
      FDM_STOP,
      FDM_SLEEP
   } fdm_mode_t;

endpackage

// *** tb/fdm_fault_manager_asserts.sv ***
// Concurrent checks on the fault manager's ports.
// Assumes a bind to the fault manager, one clock, sync active-low reset.
module fdm_fault_manager_asserts
   import fdm_pkg::*;
#(
   parameter int unsigned DOM_CYC = 64
) (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       supply_over,
   input wire logic       regulator_under,
   input wire logic       receive_short,
   input wire logic       transmit_in,
   input wire logic       high_side_hot,
   input wire logic [2:0] interrupt_mask,
   input wire logic [3:0] supply_status,
   input wire logic [3:0] bus_transceiver_status,
   input wire logic [3:0] high_side_status,
   input wire logic [3:0] interrupt_source,
   input wire logic       irq_n,
   input wire logic       host_reset_n,
   input wire logic       transmitter_enable,
   input wire logic [1:0] high_side_enable,
   input wire fdm_mode_t  mode
);
   // ************************************************************
   // Cycles of transmit input low in the normal modes
   // ************************************************************
   logic [31:0] lowc_q;
   logic [31:0] lowc_d;
   always_comb begin
      lowc_d = (!transmit_in && (mode == FDM_NORMAL || mode == FDM_NORMAL_REQ)) ?
               lowc_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk) begin
      lowc_q <= rstn ? lowc_d : 32'h0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_irq_level : assert property (irq_n == (interrupt_source == 4'h0))
      else $error("Interrupt line disagrees with source");
   chk_supply_code : assert property (
      (mode == FDM_NORMAL && supply_over && interrupt_mask == 3'h1 && interrupt_source == 4'h0)
      |=> (interrupt_source == 4'h5 && supply_status[3]))
      else $error("Supply fault code missing");
   chk_masked_quiet : assert property (
      (interrupt_mask == 3'h0 && interrupt_source == 4'h0) |=> interrupt_source == 4'h0)
      else $error("Masked fault raised a source");
   chk_no_reset_irq : assert property (
      (mode == FDM_RESET && interrupt_source == 4'h0) |=> interrupt_source == 4'h0)
      else $error("Source set in reset mode");
   chk_hs_shutdown : assert property (
      (high_side_hot && (mode == FDM_NORMAL || mode == FDM_NORMAL_REQ))
      |=> high_side_enable == 2'b00 ##[0:1] high_side_status == 4'hf)
      else $error("High side not shut down");
   chk_host_reset : assert property (
      (regulator_under && mode != FDM_SLEEP) |-> ##[0:1] !host_reset_n)
      else $error("Host reset not asserted");
   chk_short_tx_off : assert property (
      (receive_short && mode == FDM_NORMAL) |=> (!transmitter_enable && bus_transceiver_status[3]))
      else $error("Short left transmitter on");
   chk_stuck_dom : assert property (
      lowc_q == DOM_CYC + 2 |-> (!transmitter_enable && bus_transceiver_status[2]))
      else $error("Stuck dominant not caught");
endmodule

// *** tb/fdm_host_model.sv ***
// Host microcontroller model: mode commands, watchdog clears, register reads.
// Assumes the testbench maps req bits onto the serial-port request pulses.
module fdm_host_model
   import fdm_pkg::*;
(
   input  wire logic       clk,
   input  wire fdm_mode_t  mode,
   output logic [9:0]      req,
   output logic [2:0]      interrupt_mask,
   output logic [1:0]      high_side_control_on,
   output logic            high_voltage_shutdown_enable
);
   // ************************************************************
   // Request pulses and configuration
   // ************************************************************
   initial begin
      req = 10'h000;
      interrupt_mask = 3'h0;
      high_side_control_on = 2'b00;
      high_voltage_shutdown_enable = 1'b0;
   end

   // One-cycle pulse; waits up to 100 cycles for the device to leave reset mode
   task automatic send(input int b);
      int n;
      n = 0;
      while (mode == FDM_RESET && n < 100) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk) req[b] <= 1'b1;
      @(posedge clk) req[b] <= 1'b0;
   endtask

   task automatic set_cfg(input logic [2:0] m, input logic [1:0] on, input logic hv);
      @(posedge clk);
      interrupt_mask <= m;
      high_side_control_on <= on;
      high_voltage_shutdown_enable <= hv;
   endtask
endmodule

// *** tb/fdm_fault_manager_test.sv ***
// Testbench for the fault manager: supply, high side, bus and watchdog faults.
// Assumes the host model issues all serial-port requests.
module fdm_fault_manager_test
   import fdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Stimulus and instances
   // ************************************************************
   localparam int unsigned CYC = 64;
   localparam int unsigned WDC = 400;
   localparam int CMD_N = 0, WD_CLR = 3, HS_WR = 4, RD_SUP = 5, RD_BUS = 6, RD_SRC = 9;
   logic clk = 1'b0, rstn = 1'b0, supply_collapse = 1'b0, supply_over = 1'b0;
   logic supply_under = 1'b0, regulator_under = 1'b0, regulator_warn = 1'b0;
   logic regulator_hot = 1'b0, receive_short = 1'b0, transmit_in = 1'b1;
   logic bus_driver_hot = 1'b0, high_side_hot = 1'b0, wake_up = 1'b0;
   logic watchdog_config_floating = 1'b1, watchdog_config_grounded = 1'b0;
   logic [1:0] open_load = 2'b00, current_limit = 2'b00, high_side_control_on, high_side_enable;
   logic [9:0] req;
   logic [2:0] interrupt_mask;
   logic       high_voltage_shutdown_enable, irq_n, host_reset_n, regulator_enable;
   logic       transmitter_enable, watchdog_internal_base;
   logic [3:0] supply_status, bus_transceiver_status, high_side_status, watchdog_status;
   logic [3:0] interrupt_source;
   fdm_mode_t  mode;
   int         mismatches = 0;
   int         n_checks = 0;

   initial begin
      forever #4 clk = ~clk;
   end

   fdm_host_model fdm_host_model_i (.clk, .mode, .req, .interrupt_mask, .high_side_control_on,
      .high_voltage_shutdown_enable);

   fdm_fault_manager #(.DOM_CYC(CYC), .NRQ_CYC(CYC), .WD_INT_CYC(WDC)) fdm_fault_manager_i (
      .clk, .rstn, .supply_collapse, .supply_over, .supply_under, .regulator_under,
      .regulator_warn, .regulator_hot, .receive_short, .transmit_in, .bus_driver_hot,
      .high_side_hot, .open_load, .current_limit, .watchdog_config_floating,
      .watchdog_config_grounded, .cmd_normal(req[0]), .cmd_stop(req[1]), .cmd_sleep(req[2]),
      .watchdog_clear(req[3]), .wake_up, .high_side_control_wr(req[4]), .high_side_control_on,
      .high_voltage_shutdown_enable, .interrupt_mask, .rd_supply_status(req[5]),
      .rd_bus_transceiver_status(req[6]), .rd_high_side_status(req[7]),
      .rd_watchdog_status(req[8]), .rd_interrupt_source(req[9]), .supply_status,
      .bus_transceiver_status, .high_side_status, .watchdog_status, .interrupt_source, .irq_n,
      .host_reset_n, .regulator_enable, .transmitter_enable, .high_side_enable,
      .watchdog_internal_base, .mode);

   // ************************************************************
   // Helpers and scenarios
   // ************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_mode(input fdm_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 2000) begin
         tick(1);
         n++;
      end
      chk(4'(mode), 4'(m));
   endtask

   task automatic t_supply();
      fdm_host_model_i.set_cfg(3'h1, 2'b00, 1'b0);
      fdm_host_model_i.send(CMD_N);
      wait_mode(FDM_NORMAL);
      @(posedge clk) supply_over <= 1'b1;
      tick(1);
      chk(supply_status, 4'h8);
      chk(interrupt_source, 4'h5);
      chk(4'(irq_n), 4'h0);
      @(posedge clk) supply_over <= 1'b0;
      fdm_host_model_i.send(RD_SRC);
      tick(1);
      chk(4'(irq_n), 4'h1);
      fdm_host_model_i.set_cfg(3'h0, 2'b00, 1'b0);
      @(posedge clk) {supply_under, regulator_warn} <= 2'b11;
      tick(1);
      chk(supply_status, 4'he);
      chk(interrupt_source, 4'h0);
      @(posedge clk) {supply_under, regulator_warn} <= 2'b00;
      fdm_host_model_i.send(RD_SUP);
      tick(1);
      chk(supply_status, 4'h0);
      $display("supply test done");
   endtask

   task automatic t_high_side();
      fdm_host_model_i.set_cfg(3'h4, 2'b11, 1'b0);
      @(posedge clk) open_load <= 2'b01;
      tick(2);
      chk(high_side_status, 4'h2);
      chk(interrupt_source, 4'h0);
      chk(4'(high_side_enable), 4'h3);
      @(posedge clk) {open_load, high_side_hot} <= 3'b001;
      tick(2);
      chk(high_side_status, 4'hf);
      chk(interrupt_source, 4'h2);
      @(posedge clk) high_side_hot <= 1'b0;
      tick(2);
      chk(4'(high_side_enable), 4'h0);
      fdm_host_model_i.send(HS_WR);
      tick(1);
      chk(4'(high_side_enable), 4'h3);
      fdm_host_model_i.send(RD_SRC);
      fdm_host_model_i.set_cfg(3'h4, 2'b11, 1'b1);
      @(posedge clk) supply_over <= 1'b1;
      tick(1);
      chk(4'(high_side_enable), 4'h0);
      @(posedge clk) supply_over <= 1'b0;
      fdm_host_model_i.send(HS_WR);
      tick(1);
      chk(4'(high_side_enable), 4'h3);
      $display("high side test done");
   endtask

   task automatic t_bus();
      fdm_host_model_i.set_cfg(3'h2, 2'b00, 1'b0);
      @(posedge clk) transmit_in <= 1'b0;
      tick(CYC + 4);
      chk(bus_transceiver_status, 4'h4);
      chk(interrupt_source, 4'h4);
      chk(4'(transmitter_enable), 4'h0);
      @(posedge clk) transmit_in <= 1'b1;
      tick(2);
      chk(4'(transmitter_enable), 4'h1);
      fdm_host_model_i.send(RD_BUS);
      @(posedge clk) {receive_short, bus_driver_hot} <= 2'b11;
      tick(1);
      chk(bus_transceiver_status, 4'ha);
      chk(4'(transmitter_enable), 4'h0);
      @(posedge clk) {receive_short, bus_driver_hot} <= 2'b00;
      $display("bus test done");
   endtask

   task automatic t_watchdog();
      fdm_host_model_i.send(WD_CLR);
      wait_mode(FDM_NORMAL_REQ);
      chk(watchdog_status & 4'h8, 4'h8);
      @(posedge clk) regulator_under <= 1'b1;
      tick(1);
      chk(4'(host_reset_n), 4'h0);
      $display("watchdog test done");
   endtask

   task automatic t_recovery();
      wait_mode(FDM_SLEEP);
      chk(4'(regulator_enable), 4'h0);
      @(posedge clk) supply_collapse <= 1'b1;
      tick(1);
      chk(supply_status, 4'h9);
      @(posedge clk) {supply_collapse, regulator_under, wake_up} <= 3'b001;
      tick(1);
      chk(supply_status, 4'h8);
      @(posedge clk) wake_up <= 1'b0;
      wait_mode(FDM_NORMAL_REQ);
      @(posedge clk) regulator_hot <= 1'b1;
      tick(1);
      chk(4'(regulator_enable), 4'h0);
      chk(4'(mode), 4'(FDM_RESET));
      @(posedge clk) regulator_hot <= 1'b0;
      wait_mode(FDM_SLEEP);
      chk(supply_status, 4'h8);
      chk(interrupt_source, 4'h4);
      $display("recovery test done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      wait_mode(FDM_NORMAL_REQ);
      chk(watchdog_status, 4'h4);
      chk(4'(watchdog_internal_base), 4'h1);
      t_supply();
      t_high_side();
      t_bus();
      t_watchdog();
      t_recovery();
      end_of_test();
   end

   initial begin
      #(20000 * 8);
      mismatches++;
      end_of_test();
   end
endmodule

bind fdm_fault_manager fdm_fault_manager_asserts #(.DOM_CYC(DOM_CYC)) fdm_fault_manager_asserts_i (
   .clk(clk), .rstn(rstn), .supply_over(supply_over), .regulator_under(regulator_under),
   .receive_short(receive_short), .transmit_in(transmit_in), .high_side_hot(high_side_hot),
   .interrupt_mask(interrupt_mask), .supply_status(supply_status),
   .bus_transceiver_status(bus_transceiver_status), .high_side_status(high_side_status),
   .interrupt_source(interrupt_source), .irq_n(irq_n), .host_reset_n(host_reset_n),
   .transmitter_enable(transmitter_enable), .high_side_enable(high_side_enable), .mode(mode));
